/* tb_top.sv */
`timescale 1ns/10ps
`include "uart_irq_regs.svh"
module tb_top;
    logic clk, rstn, fen, enhanced_feature_reg, arts, acts, push, ovr, xoff, xon, spc, rts_n, cts_n, bclk;
    logic tfe, the, tae, irq_n, rs;
    logic [6:0] lvl, trig, spaces, stb;
    logic [2:0] perr, herr;
    logic [3:0] delta;
    logic [7:0] gpio, ier_q, interrupt_source_status, line_status_reg, wd, v, e;
    logic [31:0] seed = 32'h0001_0603;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    uart_host_model u_host (.clk(clk), .stb(stb), .wdata(wd));

    uart_irq_ctrl u_dut (
        .CLK(clk), .RSTN(rstn), .IER_WR(stb[0]), .IER_WDATA(wd), .IER_Q(ier_q),
        .ISR_RD(stb[1]), .ISR_DATA(interrupt_source_status), .LSR_RD(stb[2]), .LSR_DATA(line_status_reg),
        .RHR_RD(stb[3]), .THR_WR(stb[4]), .MSR_RD(stb[5]), .GPIO_STATE_RD(stb[6]),
        .EFR_ENH(enhanced_feature_reg), .FIFO_EN(fen), .RS485_EN(rs), .AUTO_RTS(arts), .AUTO_CTS(acts),
        .RX_LEVEL(lvl), .RX_TRIG(trig), .RX_PUSH(push), .RX_PUSH_ERR(perr),
        .RX_HEAD_ERR(herr), .RX_OVERRUN(ovr), .TX_SPACES(spaces), .TX_TRIG(7'h08),
        .TX_FIFO_EMPTY(tfe), .THR_EMPTY(the), .TX_ALL_EMPTY(tae), .MSR_DELTA(delta),
        .XOFF_DET(xoff), .XON_DET(xon), .SPECIAL_DET(spc), .RTS_N_PIN(rts_n),
        .CTS_N(cts_n), .GPIO_IN(gpio), .BIT_CLK(bclk), .CHAR_BITS(4'h4), .IRQ_N(irq_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        bclk = 1'b0;
        #3;
        forever #80 bclk = ~bclk;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] nxt(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : nxt
    function automatic logic [7:0] ix(input logic [5:0] c);
        return {(fen ? `ISR_FIFO_MODE : `ISR_NO_FIFO), c};
    endfunction : ix
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask : settle
    task automatic acc(input int unsigned i, input logic [7:0] d);
        u_host.access(i, d);
        settle();
    endtask : acc
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        settle();
    endtask : pulse
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        n_tests++;
        if (got !== ex) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic done(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, n_fail);
    endtask : done
    task automatic rst();
        rstn = 1'b0;
        repeat (10) @(negedge clk);
        chk("ier_rst", `IER_RESET, ier_q);
        chk("isr_rst", 8'h01, interrupt_source_status);
        chk("lsr_rst", 8'h60, line_status_reg);
        chk("irq_rst", 8'h01, {7'h00, irq_n});
        rstn = 1'b1;
        settle();
    endtask : rst
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        {fen, enhanced_feature_reg, arts, acts, push, ovr, xoff, xon, spc, rts_n, cts_n} = 11'h000;
        {tfe, the, tae} = 3'b111;
        rs = 1'b0;
        {lvl, trig, perr, herr, delta, gpio} = '0;
        spaces = 7'h10;
        rst();
        acc(0, 8'hFF);
        chk("ier_lock", 8'h0F, ier_q);
        e = 8'h0F;
        for (int i = 0; i < 6; i++) begin
            enhanced_feature_reg = i[0];
            seed = nxt(seed);
            v = seed[7:0];
            spaces = seed[14:8];
            e = enhanced_feature_reg ? v : {e[7:4], v[3:0]};
            acc(0, v);
            chk("ier", e, ier_q);
        end
        enhanced_feature_reg = 1'b1;
        acc(0, 8'h00);
        done("enable_mask");
        fen = 1'b1;
        trig = 7'h08;
        lvl = 7'h08;
        pulse(push);
        chk("lsr0", 8'h01, {7'h00, line_status_reg[0]});
        chk("isr_poll", ix(`ISR_NONE), interrupt_source_status);
        chk("irq_poll", 8'h01, {7'h00, irq_n});
        acc(0, 8'h01);
        chk("isr_rx", ix(`ISR_RX_DATA), interrupt_source_status);
        chk("irq_rx", 8'h00, {7'h00, irq_n});
        lvl = 7'h07;
        settle();
        chk("isr_below", ix(`ISR_NONE), interrupt_source_status);
        chk("irq_below", 8'h01, {7'h00, irq_n});
        lvl = 7'h00;
        settle();
        chk("lsr0_empty", 8'h00, {7'h00, line_status_reg[0]});
        fen = 1'b0;
        settle();
        chk("isr_nofifo", 8'h01, interrupt_source_status);
        fen = 1'b1;
        done("rx_data");
        acc(0, 8'h02);
        chk("isr_tx", ix(`ISR_TX_READY), interrupt_source_status);
        acc(1, 8'h00);
        chk("isr_tx_rd", ix(`ISR_NONE), interrupt_source_status);
        acc(0, 8'h00);
        acc(0, 8'h02);
        chk("isr_tx_en", ix(`ISR_TX_READY), interrupt_source_status);
        {tfe, the, tae} = 3'b000;
        spaces = 7'h00;
        acc(4, 8'h00);
        chk("isr_tx_wr", ix(`ISR_NONE), interrupt_source_status);
        chk("lsr_tx_busy", 8'h00, {6'h00, line_status_reg[6:5]});
        {tfe, the, tae} = 3'b111;
        settle();
        chk("lsr_tx_idle", 8'h03, {6'h00, line_status_reg[6:5]});
        chk("isr_tx_empty", ix(`ISR_TX_READY), interrupt_source_status);
        acc(0, 8'h00);
        chk("isr_tx_off", ix(`ISR_NONE), interrupt_source_status);
        rs = 1'b1;
        tae = 1'b0;
        acc(0, 8'h02);
        acc(4, 8'h00);
        chk("isr_485_busy", ix(`ISR_NONE), interrupt_source_status);
        tae = 1'b1;
        settle();
        chk("isr_485_idle", ix(`ISR_TX_READY), interrupt_source_status);
        acc(0, 8'h00);
        rs = 1'b0;
        done("tx_ready");
        acc(0, 8'h05);
        lvl = 7'h08;
        settle();
        pulse(ovr);
        chk("isr_ovr", ix(`ISR_LINE), interrupt_source_status);
        chk("lsr_ovr", 8'h01, {7'h00, line_status_reg[1]});
        acc(2, 8'h00);
        chk("lsr_ovr_rd", 8'h00, {7'h00, line_status_reg[1]});
        chk("isr_next", ix(`ISR_RX_DATA), interrupt_source_status);
        herr = 3'b101;
        settle();
        chk("lsr_head", 8'h05, {5'h00, line_status_reg[4:2]});
        chk("isr_head", ix(`ISR_LINE), interrupt_source_status);
        herr = 3'b000;
        perr = 3'b010;
        pulse(push);
        chk("lsr7", 8'h01, {7'h00, line_status_reg[7]});
        acc(2, 8'h00);
        chk("isr_err_held", ix(`ISR_LINE), interrupt_source_status);
        perr = 3'b000;
        lvl = 7'h00;
        rst();
        done("line_status");
        acc(0, 8'h08);
        for (int i = 0; i < 4; i++) begin
            delta = 4'h0;
            delta[i] = 1'b1;
            settle();
            chk("isr_msr", ix(`ISR_MODEM), interrupt_source_status);
            chk("irq_msr", 8'h00, {7'h00, irq_n});
            delta = 4'h0;
            settle();
            chk("isr_msr_off", ix(`ISR_NONE), interrupt_source_status);
        end
        seed = nxt(seed);
        gpio = gpio ^ (seed[7:0] | 8'h01);
        settle();
        chk("isr_gpio", ix(`ISR_GPIO), interrupt_source_status);
        delta = 4'h2;
        settle();
        chk("isr_prio", ix(`ISR_MODEM), interrupt_source_status);
        delta = 4'h0;
        settle();
        chk("isr_gpio2", ix(`ISR_GPIO), interrupt_source_status);
        acc(6, 8'h00);
        chk("isr_gpio_rd", ix(`ISR_NONE), interrupt_source_status);
        done("modem_gpio");
        enhanced_feature_reg = 1'b1;
        acc(0, 8'h20);
        pulse(xoff);
        chk("isr_xoff", ix(`ISR_XOFF), interrupt_source_status);
        pulse(xon);
        chk("isr_xon", ix(`ISR_NONE), interrupt_source_status);
        pulse(spc);
        chk("isr_spc", ix(`ISR_XOFF), interrupt_source_status);
        acc(1, 8'h00);
        chk("isr_spc_rd", ix(`ISR_NONE), interrupt_source_status);
        {arts, acts} = 2'b11;
        acc(0, 8'h80);
        cts_n = 1'b1;
        settle();
        chk("isr_cts", ix(`ISR_FLOW), interrupt_source_status);
        acc(5, 8'h00);
        chk("isr_cts_rd", ix(`ISR_NONE), interrupt_source_status);
        acc(0, 8'h40);
        rts_n = 1'b1;
        settle();
        chk("isr_rts", ix(`ISR_FLOW), interrupt_source_status);
        acc(5, 8'h00);
        chk("isr_rts_rd", ix(`ISR_NONE), interrupt_source_status);
        done("xoff_flow");
        acc(0, 8'h01);
        lvl = 7'h01;
        repeat (400) @(negedge clk);
        chk("isr_to_early", ix(`ISR_NONE), interrupt_source_status);
        for (int k = 0; k < 200 && interrupt_source_status !== ix(`ISR_RX_TIMEOUT); k++) @(negedge clk);
        chk("isr_to", ix(`ISR_RX_TIMEOUT), interrupt_source_status);
        u_host.access(3, 8'h00);
        lvl = 7'h00;
        settle();
        chk("isr_to_rd", ix(`ISR_NONE), interrupt_source_status);
        done("rx_timeout");
        results();
    end
endmodule : tb_top

/* uart_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// host side: register strobes from the host port decoder
module uart_host_model (
    input wire logic clk,
    output logic [6:0] stb,
    output logic [7:0] wdata
);
    initial begin
        stb = 7'h00;
        wdata = 8'h00;
    end

    task automatic access(input int unsigned idx, input logic [7:0] wd);
        @(negedge clk);
        wdata = wd;
        stb[idx] = 1'b1;
        @(negedge clk);
        stb = 7'h00;
        wdata = ~wd;
    endtask : access
endmodule : uart_host_model

/* uart_irq_ctrl.sv */
// Overview of operation
// RL1 - rx data irq follows fifo trigger level
// RL2 - data ready set while fifo level nonzero, cleared empty
// RL3 - all low enables give polled mode except gpio toggle irq, which has no enable
// RL4 - line status shows thr, tx empty, overrun
// RL5 - bit7 set while fifo holds errored char
// RL6 - bits 4:2 show head character errors
// RL7 - enable bit0 gates receive data irq
// RL8 - enable bit1 gates tx ready, immediate
// RL9 - enable bit2 gates line status irq
// RL10 - overrun raises line irq at once
// RL11 - enable bit3 gates modem status irq
// RL12 - upper enable bits need enhanced bit
// RL13 - rts/cts rising edges raise irq
// RL14 - status shows highest pending source code
// RL15 - rx timeout after four chars twelve bits
// RL16 - tx ready from trigger, empty, rs485
// RL17 - gpio toggle irq, cleared reading gpio
// RL18 - line irq holds until errors read
// RL19 - rx timeout cleared reading rx holding
// RL20 - tx ready cleared status read, write
// RL21 - modem read clears flow irqs; modem irq follows delta bits
// RL22 - xoff cleared by xon, special by read
// RL23 - status bit0 low while anything pending
// RL24 - fixed priority order of eight sources
// RL25 - status bits 7:6 show fifo mode
// RL26 - irq output while enabled source pending
`timescale 1ns/10ps
`include "uart_irq_regs.svh"
module uart_irq_ctrl
    import uart_irq_pkg::*;
#(
    parameter int LVL_W = 7,
    parameter int GPIO_W = 8
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic IER_WR,
    input wire logic [7:0] IER_WDATA,
    output logic [7:0] IER_Q,
    input wire logic ISR_RD,
    output logic [7:0] ISR_DATA,
    input wire logic LSR_RD,
    output logic [7:0] LSR_DATA,
    input wire logic RHR_RD,
    input wire logic THR_WR,
    input wire logic MSR_RD,
    input wire logic GPIO_STATE_RD,
    input wire logic EFR_ENH,
    input wire logic FIFO_EN,
    input wire logic RS485_EN,
    input wire logic AUTO_RTS,
    input wire logic AUTO_CTS,
    input wire logic [LVL_W-1:0] RX_LEVEL,
    input wire logic [LVL_W-1:0] RX_TRIG,
    input wire logic RX_PUSH,
    input wire logic [2:0] RX_PUSH_ERR,
    input wire logic [2:0] RX_HEAD_ERR,
    input wire logic RX_OVERRUN,
    input wire logic [LVL_W-1:0] TX_SPACES,
    input wire logic [LVL_W-1:0] TX_TRIG,
    input wire logic TX_FIFO_EMPTY,
    input wire logic THR_EMPTY,
    input wire logic TX_ALL_EMPTY,
    input wire logic [3:0] MSR_DELTA,
    input wire logic XOFF_DET,
    input wire logic XON_DET,
    input wire logic SPECIAL_DET,
    input wire logic RTS_N_PIN,
    input wire logic CTS_N,
    input wire logic [GPIO_W-1:0] GPIO_IN,
    input wire logic BIT_CLK,
    input wire logic [3:0] CHAR_BITS,
    output logic IRQ_N
);
    // ======================================================
    // pin synchronisers and edges
    logic [GPIO_W+1:0] pins_s;
    logic bit_clk_s, cts_s, bit_clk_p, cts_p, rts_p;
    logic [GPIO_W-1:0] gpio_s, gpio_p;
    logic bit_tick;

    uart_irq_sync #(.W(GPIO_W + 2)) u_sync (
        .clk(CLK),
        .rst_n(RSTN),
        .d({BIT_CLK, CTS_N, GPIO_IN}),
        .q(pins_s)
    );
    assign bit_clk_s = pins_s[GPIO_W+1];
    assign cts_s = pins_s[GPIO_W];
    assign gpio_s = pins_s[GPIO_W-1:0];
    assign bit_tick = rose(bit_clk_p, bit_clk_s);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            bit_clk_p <= 1'b0;
            cts_p <= 1'b0;
            rts_p <= 1'b0;
            gpio_p <= '0;
        end else begin
            bit_clk_p <= bit_clk_s;
            cts_p <= cts_s;
            rts_p <= RTS_N_PIN;
            gpio_p <= gpio_s;
        end
    end

    // ======================================================
    // interrupt enable mask
    logic ier1_p;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            IER_Q <= `IER_RESET;
        end else if (IER_WR) begin
            IER_Q[3:0] <= IER_WDATA[3:0];
            // RL12 upper bits locked
            if (EFR_ENH) begin
                IER_Q[7:4] <= IER_WDATA[7:4];
            end
        end
    end

    // ======================================================
    // line status
    logic ovr_q;
    logic [LVL_W-1:0] err_cnt_q;
    logic push_err, pop_err, rx_has_data;

    assign push_err = RX_PUSH && (RX_PUSH_ERR != 3'h0);
    assign pop_err = RHR_RD && rx_has_data && (RX_HEAD_ERR != 3'h0);
    assign rx_has_data = (RX_LEVEL != '0);

    // RL5 count errored chars
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            err_cnt_q <= '0;
        end else if (push_err && !pop_err) begin
            err_cnt_q <= err_cnt_q + 1'b1;
        end else if (pop_err && !push_err && err_cnt_q != '0) begin
            err_cnt_q <= err_cnt_q - 1'b1;
        end
    end

    // RL10 overrun caught at once
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ovr_q <= 1'b0;
        end else if (RX_OVERRUN) begin
            ovr_q <= 1'b1;
        end else if (LSR_RD) begin
            ovr_q <= 1'b0;
        end
    end

    logic [7:0] lsr_d;
    always_comb begin
        // RL2 data ready while fifo not empty
        lsr_d[0] = rx_has_data;
        // RL4 overrun and transmitter flags
        lsr_d[1] = ovr_q;
        lsr_d[5] = THR_EMPTY;
        lsr_d[6] = TX_ALL_EMPTY;
        // RL6 head character errors
        lsr_d[4:2] = rx_has_data ? RX_HEAD_ERR : 3'h0;
        // RL5 any errored char
        lsr_d[7] = (err_cnt_q != '0);
    end

    // RL3 status polled regardless of enables
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            LSR_DATA <= 8'h60;
        end else begin
            LSR_DATA <= lsr_d;
        end
    end

    // ======================================================
    // receive timeout
    logic to_fired;

    // RL15 four chars plus twelve bits
    // RL19 restart on holding read
    uart_irq_timeout u_timeout (
        .clk(CLK),
        .rst_n(RSTN),
        .bit_tick(bit_tick),
        .char_bits(CHAR_BITS),
        .data_waiting(rx_has_data),
        .restart(RX_PUSH || RHR_RD),
        .fired(to_fired)
    );

    // ======================================================
    // sticky event flags
    logic tx_cond, tx_cond_p, tx_set, tx_q;
    logic gpio_q, xoff_q, special_q, rts_q, cts_q;
    logic [5:0] isr_code_q;

    // RL16 tx ready condition
    assign tx_cond = RS485_EN ? TX_ALL_EMPTY :
        FIFO_EN ? ((TX_SPACES > TX_TRIG) || TX_FIFO_EMPTY) : THR_EMPTY;
    // RL8 enabling while empty fires
    assign tx_set = rose(tx_cond_p, tx_cond) ||
        (rose(ier1_p, IER_Q[`IER_TX_READY]) && tx_cond);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_cond_p <= 1'b0;
            ier1_p <= 1'b0;
        end else begin
            tx_cond_p <= tx_cond;
            ier1_p <= IER_Q[`IER_TX_READY];
        end
    end

    // RL20 tx ready clears, set wins
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_q <= 1'b0;
        end else if (tx_set) begin
            tx_q <= 1'b1;
        end else if (THR_WR || (ISR_RD && isr_code_q == `ISR_TX_READY)) begin
            tx_q <= 1'b0;
        end
    end

    // RL17 gpio toggle flag
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            gpio_q <= 1'b0;
        end else if (gpio_s != gpio_p) begin
            gpio_q <= 1'b1;
        end else if (GPIO_STATE_RD) begin
            gpio_q <= 1'b0;
        end
    end

    // RL22 xoff and special char flags
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            xoff_q <= 1'b0;
            special_q <= 1'b0;
        end else begin
            if (XOFF_DET) begin
                xoff_q <= 1'b1;
            end else if (XON_DET) begin
                xoff_q <= 1'b0;
            end
            if (SPECIAL_DET) begin
                special_q <= 1'b1;
            end else if (ISR_RD) begin
                special_q <= 1'b0;
            end
        end
    end

    // RL13 rts and cts rising edges
    // RL21 modem read clears flow flags
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rts_q <= 1'b0;
            cts_q <= 1'b0;
        end else begin
            if (rose(rts_p, RTS_N_PIN) && AUTO_RTS && IER_Q[`IER_RTS]) begin
                rts_q <= 1'b1;
            end else if (MSR_RD) begin
                rts_q <= 1'b0;
            end
            if (rose(cts_p, cts_s) && AUTO_CTS && IER_Q[`IER_CTS]) begin
                cts_q <= 1'b1;
            end else if (MSR_RD) begin
                cts_q <= 1'b0;
            end
        end
    end

    // ======================================================
    // gated sources and priority
    logic line_src, to_src, rx_src, txr_src, msr_src, gpio_src, xoff_src, flow_src;
    logic pend_any;
    logic [5:0] code_d;

    // RL9 line status gate
    // RL18 held by errored chars
    assign line_src = IER_Q[`IER_LINE] && (lsr_d[1] || lsr_d[4:2] != 3'h0 || lsr_d[7]);
    // RL7 receive data gate
    assign to_src = IER_Q[`IER_RX_DATA] && to_fired;
    // RL1 fifo trigger level
    assign rx_src = IER_Q[`IER_RX_DATA] && (FIFO_EN ? (RX_LEVEL >= RX_TRIG) : rx_has_data);
    assign txr_src = IER_Q[`IER_TX_READY] && tx_q;
    // RL11 modem delta bits
    assign msr_src = IER_Q[`IER_MODEM] && (MSR_DELTA != 4'h0);
    assign gpio_src = gpio_q;
    assign xoff_src = EFR_ENH && IER_Q[`IER_XOFF] && (xoff_q || special_q);
    assign flow_src = EFR_ENH && ((rts_q && IER_Q[`IER_RTS]) || (cts_q && IER_Q[`IER_CTS]));
    assign pend_any = line_src || to_src || rx_src || txr_src || msr_src ||
        gpio_src || xoff_src || flow_src;

    // RL24 fixed priority
    always_comb begin
        if (line_src) begin
            code_d = `ISR_LINE;
        end else if (to_src) begin
            code_d = `ISR_RX_TIMEOUT;
        end else if (rx_src) begin
            code_d = `ISR_RX_DATA;
        end else if (txr_src) begin
            code_d = `ISR_TX_READY;
        end else if (msr_src) begin
            code_d = `ISR_MODEM;
        end else if (gpio_src) begin
            code_d = `ISR_GPIO;
        end else if (xoff_src) begin
            code_d = `ISR_XOFF;
        end else if (flow_src) begin
            code_d = `ISR_FLOW;
        end else begin
            code_d = `ISR_NONE;
        end
    end

    // RL14 highest pending code
    // RL23 bit0 low when pending
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            isr_code_q <= `ISR_NONE;
        end else begin
            isr_code_q <= code_d;
        end
    end

    // RL25 fifo mode bits
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ISR_DATA <= {`ISR_NO_FIFO, `ISR_NONE};
        end else begin
            ISR_DATA <= {FIFO_EN ? `ISR_FIFO_MODE : `ISR_NO_FIFO, code_d};
        end
    end

    // RL26 interrupt output
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            IRQ_N <= 1'b1;
        end else begin
            IRQ_N <= !pend_any;
        end
    end

    // ======================================================
    // assertions
    sequence s_ovr;
        IER_Q[`IER_LINE] && RX_OVERRUN;
    endsequence

    property p_ovr_line;
        @(posedge CLK) disable iff (!RSTN)
        s_ovr ##1 !LSR_RD |=> ISR_DATA[5:0] == `ISR_LINE;
    endproperty
    a_ovr_line: assert property (p_ovr_line) else $error("overrun not reported"); // RL10

    property p_isr_bit0;
        @(posedge CLK) disable iff (!RSTN)
        pend_any |=> !ISR_DATA[0] && !IRQ_N;
    endproperty
    a_isr_bit0: assert property (p_isr_bit0) else $error("pending not shown"); // RL23

    property p_fifo_bits;
        @(posedge CLK) disable iff (!RSTN)
        FIFO_EN |=> ISR_DATA[7:6] == `ISR_FIFO_MODE;
    endproperty
    a_fifo_bits: assert property (p_fifo_bits) else $error("fifo bits wrong"); // RL25

    property p_ier_lock;
        @(posedge CLK) disable iff (!RSTN)
        IER_WR && !EFR_ENH |=> IER_Q[7:4] == $past(IER_Q[7:4]);
    endproperty
    a_ier_lock: assert property (p_ier_lock) else $error("locked bits written"); // RL12

    property p_tx_clear;
        @(posedge CLK) disable iff (!RSTN)
        THR_WR && !tx_set |=> !tx_q;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("tx ready not cleared"); // RL20

    property p_gpio_set;
        @(posedge CLK) disable iff (!RSTN)
        gpio_s != gpio_p |=> gpio_q;
    endproperty
    a_gpio_set: assert property (p_gpio_set) else $error("gpio toggle lost"); // RL17

    property p_err_bit7;
        @(posedge CLK) disable iff (!RSTN)
        err_cnt_q != '0 |=> LSR_DATA[7];
    endproperty
    a_err_bit7: assert property (p_err_bit7) else $error("error bit missing"); // RL5

    property p_rx_trig;
        @(posedge CLK) disable iff (!RSTN)
        FIFO_EN && IER_Q[`IER_RX_DATA] && RX_LEVEL >= RX_TRIG |=> !IRQ_N;
    endproperty
    a_rx_trig: assert property (p_rx_trig) else $error("rx trigger irq missing"); // RL1

    property p_polled;
        @(posedge CLK) disable iff (!RSTN)
        IER_Q == 8'h00 && !gpio_src |=> ISR_DATA[5:0] == `ISR_NONE;
    endproperty
    a_polled: assert property (p_polled) else $error("polled mode irq"); // RL3
endmodule : uart_irq_ctrl

/* uart_irq_pkg.sv */
package uart_irq_pkg;

    typedef enum logic [1:0] {
        TO_IDLE = 2'b00,
        TO_RUN = 2'b01,
        TO_FIRED = 2'b11
    } timeout_state_t;

    typedef logic [5:0] isr_code_t;

    function automatic logic rose(input logic prev, input logic now);
        rose = !prev && now;
    endfunction : rose

endpackage : uart_irq_pkg

/* uart_irq_regs.svh */
`ifndef UART_IRQ_REGS_SVH
`define UART_IRQ_REGS_SVH

// ==========================================================
// interrupt enable mask
`define IER_RESET 8'h00
`define IER_RX_DATA 0
`define IER_TX_READY 1
`define IER_LINE 2
`define IER_MODEM 3
`define IER_XOFF 5
`define IER_RTS 6
`define IER_CTS 7

// ==========================================================
// interrupt source codes, bits 5:0
`define ISR_NONE 6'h01
`define ISR_LINE 6'h06
`define ISR_RX_TIMEOUT 6'h0C
`define ISR_RX_DATA 6'h04
`define ISR_TX_READY 6'h02
`define ISR_MODEM 6'h00
`define ISR_GPIO 6'h30
`define ISR_XOFF 6'h10
`define ISR_FLOW 6'h20
`define ISR_FIFO_MODE 2'h3
`define ISR_NO_FIFO 2'h0

// ==========================================================
// receive timeout, in characters and bit times
`define TO_CHARS 8'h04
`define TO_BITS 8'h0C

`endif

/* uart_irq_sync.sv */
`timescale 1ns/10ps
module uart_irq_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : uart_irq_sync

/* uart_irq_timeout.sv */
`timescale 1ns/10ps
`include "uart_irq_regs.svh"
module uart_irq_timeout
    import uart_irq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_tick,
    input wire logic [3:0] char_bits,
    input wire logic data_waiting,
    input wire logic restart,
    output logic fired
);
    timeout_state_t state_q;
    logic [7:0] count_q;
    logic [7:0] limit;

    // four characters plus twelve bits
    assign limit = 8'(`TO_CHARS * {4'h0, char_bits}) + `TO_BITS;
    assign fired = (state_q == TO_FIRED);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= TO_IDLE;
            count_q <= 8'h00;
        end else if (!data_waiting) begin
            state_q <= TO_IDLE;
            count_q <= 8'h00;
        end else if (restart) begin
            state_q <= TO_RUN;
            count_q <= 8'h00;
        end else begin
            unique case (state_q)
                TO_IDLE: begin
                    state_q <= TO_RUN;
                    count_q <= 8'h00;
                end
                TO_RUN: begin
                    if (bit_tick) begin
                        count_q <= count_q + 8'h01;
                        if (count_q + 8'h01 >= limit) begin
                            state_q <= TO_FIRED;
                        end
                    end
                end
                TO_FIRED: begin
                    state_q <= TO_FIRED;
                end
                default: begin
                    state_q <= TO_IDLE;
                end
            endcase
        end
    end
endmodule : uart_irq_timeout
